// ==== design/rst_clk_pkg.sv ====
// Constants and carrier types for the reset sequencer and clock-option block
package rst_clk_pkg;

  // Timing: one instruction cycle per clock at 50 MHz
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int INSTR_CYCLE_TIME_NS = 20;
  localparam int CM_RECOVER_TC = 16;
  localparam logic [5:0] CM_RECOVER_CYC =
    6'(CM_RECOVER_TC * INSTR_CYCLE_TIME_NS / CLOCK_PERIOD_NS);
  localparam int WD_WINDOW_TC = 65536;
  localparam int WD_WINDOW_CYC_DEF = WD_WINDOW_TC * INSTR_CYCLE_TIME_NS / CLOCK_PERIOD_NS;
  localparam logic [11:0] IDLE_PRESET = 12'hfff;

  // Configuration fuse image
  localparam int CFG_POR_EN_BIT = 6;
  localparam int CFG_OSC_HI_BIT = 4;
  localparam int CFG_OSC_LO_BIT = 3;
  localparam int CFG_WD_DIS_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h40;

  // Values after reset
  localparam logic [7:0] SER_CTRL_RESET = 8'h02;
  localparam int TX_EMPTY_BIT = 1;
  localparam logic [1:0] WD_WIN_RESET = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_DATA_SEG = 8'h0c;
  localparam logic [7:0] OFF_SER_PRESC = 8'h10;
  localparam logic [7:0] OFF_SER_CTRL = 8'h14;
  localparam logic [7:0] OFF_SER_RX = 8'h18;
  localparam logic [7:0] OFF_SER_IRQ = 8'h1c;
  localparam logic [7:0] OFF_CMP_SEL = 8'h20;
  localparam logic [7:0] OFF_SUPERVISOR = 8'h24;
  localparam logic [7:0] OFF_STATE = 8'h28;

  // Status, mask and supervisor service bit positions
  localparam int ST_POR = 0;
  localparam int ST_EXT = 1;
  localparam int ST_CM = 2;
  localparam int ST_WD = 3;
  localparam int SUP_SERVICE_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OSC_EXT = 2'h0,
    OSC_RC = 2'h1,
    OSC_XTAL = 2'h2,
    OSC_XTAL_BIAS = 2'h3
  } osc_mode_t;

  typedef enum logic [2:0] {
    SEQ_RUN = 3'h1,
    SEQ_POR = 3'h2,
    SEQ_EXT = 3'h4
  } seq_state_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage

// ==== design/pin_sync.sv ====
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // First stage feeds only the second one
  always_comb
  begin
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign sync_out = s.stage2;
endmodule // pin_sync

// ==== design/reset_and_clock_option_ctrl.sv ====
// Reset sequencer, supervisor and clock-option decode with an AXI4-Lite register slave
`timescale 1ns/1ns
// Behaviour
// - Any reset clears data segment register
// - Reset clears serial, comparator regs; tx-empty set
// - Reset sets max window, arms supervisor, monitor
// - Supervisor and monitor inhibited during reset
// - Slow clock at reset end flags monitor
// - Monitor error holds pin low until recovery
// - Reset pin also exits halt state
// - Power-on reset held until idle underflow
// - Power-on reset acts like external reset
// - No new power-on reset while supply stays
// - Fuse bits 4,3 select oscillator mode
// - Clock pin drives crystal or serves input
// - Power-on path enabled by fuse bit 6
// - Fuse bit 2 zero enables supervisor pin
// - Idle timer counts down every cycle except when power-on presets it
module reset_and_clock_option_ctrl #(
  parameter int WD_WINDOW_CYC = rst_clk_pkg::WD_WINDOW_CYC_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire rst_clk_pkg::axil_req_t bus_req,
  output rst_clk_pkg::axil_rsp_t bus_rsp,
  // Asynchronous pins
  input wire logic reset_pin_n,
  input wire logic vcc_above_por,
  input wire logic clock_freq_ok,
  // Reset, halt exit and interrupt
  output logic core_reset,
  output logic halt_exit,
  output logic irq,
  // Supervisor error pin
  output logic supervisor_error_pin_out,
  output logic supervisor_error_pin_oe,
  // Oscillator option
  output rst_clk_pkg::osc_mode_t osc_mode,
  output logic osc_out_drive_en,
  output logic osc_out_gp_input_en,
  output logic osc_bias_res_en
);
  localparam int WDW = $clog2(WD_WINDOW_CYC + 1);

  typedef struct packed {
    rst_clk_pkg::seq_state_t seq;
    logic [11:0] idle_cnt;
    logic vcc_prev;
    logic rstn_prev;
    logic ram_undef;
    logic [7:0] cfg;
    logic [7:0] data_seg;
    logic [7:0] ser_presc;
    logic [7:0] ser_ctrl;
    logic [7:0] ser_rx;
    logic [7:0] ser_irq;
    logic [7:0] cmp_sel;
    logic [1:0] wd_win;
    logic wd_armed;
    logic cm_armed;
    logic [WDW-1:0] wd_cnt;
    logic wd_err;
    logic cm_err;
    logic [5:0] cm_cnt;
    logic [3:0] status;
    logic [3:0] mask;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    rst_clk_pkg::axil_rsp_t rsp;
    logic core_reset;
    logic halt_exit;
    logic irq;
    logic err_out;
    logic err_oe;
    logic drv_en;
    logic gp_en;
    logic bias_en;
    rst_clk_pkg::osc_mode_t osc;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;
  logic [2:0] pins_s;
  logic rstn_s;
  logic vcc_s;
  logic clk_ok_s;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {rst_clk_pkg::OFF_CONFIG, rst_clk_pkg::OFF_STATUS, rst_clk_pkg::OFF_MASK,
      rst_clk_pkg::OFF_DATA_SEG, rst_clk_pkg::OFF_SER_PRESC, rst_clk_pkg::OFF_SER_CTRL,
      rst_clk_pkg::OFF_SER_RX, rst_clk_pkg::OFF_SER_IRQ, rst_clk_pkg::OFF_CMP_SEL,
      rst_clk_pkg::OFF_SUPERVISOR, rst_clk_pkg::OFF_STATE};
  endfunction

  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [31:0] d,
    input logic [3:0] strb);
    wr8 = strb[0] ? d[7:0] : old;
  endfunction

  // Reset pin needs one full cycle low to be seen after synchronising
  pin_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({reset_pin_n, vcc_above_por, clock_freq_ok}),
    .sync_out(pins_s)
  );

  assign rstn_s = pins_s[2];
  assign vcc_s = pins_s[1];
  assign clk_ok_s = pins_s[0];

  always_comb
  begin
    logic por_evt;
    logic ext_evt;
    logic in_reset;
    logic wd_on;
    logic service;
    logic ar_hs;
    logic [3:0] ev;
    logic [3:0] st_clr;
    logic [31:0] rd;
    logic [WDW-1:0] win;
    por_evt = 1'b0;
    ext_evt = 1'b0;
    in_reset = 1'b0;
    wd_on = 1'b0;
    service = 1'b0;
    ar_hs = 1'b0;
    ev = 4'h0;
    st_clr = 4'h0;
    rd = 32'h0;
    win = WDW'(WD_WINDOW_CYC >> (3 - int'(s.wd_win)));
    next_s = s;
    next_s.vcc_prev = vcc_s;
    next_s.rstn_prev = rstn_s;
    // Only a rising supply fires, so a steady supply gives no further reset
    por_evt = s.cfg[rst_clk_pkg::CFG_POR_EN_BIT] && vcc_s && !s.vcc_prev;
    ext_evt = !rstn_s && s.rstn_prev;
    next_s.idle_cnt = s.idle_cnt - 12'h001;
    if (por_evt)
      next_s.idle_cnt = rst_clk_pkg::IDLE_PRESET;

    unique case (s.seq)
      rst_clk_pkg::SEQ_RUN:
        if (por_evt)
          next_s.seq = rst_clk_pkg::SEQ_POR;
        else if (!rstn_s)
          next_s.seq = rst_clk_pkg::SEQ_EXT;
      rst_clk_pkg::SEQ_POR:
        if (!por_evt && s.idle_cnt == 12'h000)
          next_s.seq = rstn_s ? rst_clk_pkg::SEQ_RUN : rst_clk_pkg::SEQ_EXT;
      rst_clk_pkg::SEQ_EXT:
        if (por_evt)
          next_s.seq = rst_clk_pkg::SEQ_POR;
        else if (rstn_s)
          next_s.seq = rst_clk_pkg::SEQ_RUN;
    endcase
    in_reset = next_s.seq != rst_clk_pkg::SEQ_RUN;

    // Register bus: write channels
    if (s.rsp.bvalid && bus_req.bready)
      next_s.rsp.bvalid = 1'b0;
    if (bus_req.awvalid && s.rsp.awready)
    begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = bus_req.awaddr[7:0];
    end
    if (bus_req.wvalid && s.rsp.wready)
    begin
      next_s.w_full = 1'b1;
      next_s.w_data = bus_req.wdata;
      next_s.w_strb = bus_req.wstrb;
    end
    if (s.aw_full && s.w_full && !s.rsp.bvalid)
    begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = mapped(s.aw_addr) ? rst_clk_pkg::RESP_OKAY : rst_clk_pkg::RESP_SLVERR;
      case (s.aw_addr)
        rst_clk_pkg::OFF_CONFIG: next_s.cfg = wr8(s.cfg, s.w_data, s.w_strb);
        rst_clk_pkg::OFF_MASK: next_s.mask = s.w_strb[0] ? s.w_data[3:0] : s.mask;
        rst_clk_pkg::OFF_DATA_SEG: next_s.data_seg = wr8(s.data_seg, s.w_data, s.w_strb);
        rst_clk_pkg::OFF_SER_PRESC: next_s.ser_presc = wr8(s.ser_presc, s.w_data, s.w_strb);
        rst_clk_pkg::OFF_SER_CTRL: next_s.ser_ctrl = wr8(s.ser_ctrl, s.w_data, s.w_strb);
        rst_clk_pkg::OFF_SER_RX: next_s.ser_rx = wr8(s.ser_rx, s.w_data, s.w_strb);
        rst_clk_pkg::OFF_SER_IRQ: next_s.ser_irq = wr8(s.ser_irq, s.w_data, s.w_strb);
        rst_clk_pkg::OFF_CMP_SEL: next_s.cmp_sel = wr8(s.cmp_sel, s.w_data, s.w_strb);
        rst_clk_pkg::OFF_SUPERVISOR:
        begin
          if (s.w_strb[0])
            next_s.wd_win = s.w_data[1:0];
          service = s.w_strb[1] && s.w_data[rst_clk_pkg::SUP_SERVICE_BIT];
        end
        rst_clk_pkg::OFF_STATE:
          if (s.w_strb[0] && s.w_data[0])
            next_s.ram_undef = 1'b0;
        default: ;
      endcase
    end

    // Register bus: read channels; status clears on the address handshake
    if (s.rsp.rvalid && bus_req.rready)
      next_s.rsp.rvalid = 1'b0;
    ar_hs = bus_req.arvalid && s.rsp.arready;
    case (bus_req.araddr[7:0])
      rst_clk_pkg::OFF_CONFIG: rd = {24'h0, s.cfg};
      rst_clk_pkg::OFF_STATUS: rd = {28'h0, s.status};
      rst_clk_pkg::OFF_MASK: rd = {28'h0, s.mask};
      rst_clk_pkg::OFF_DATA_SEG: rd = {24'h0, s.data_seg};
      rst_clk_pkg::OFF_SER_PRESC: rd = {24'h0, s.ser_presc};
      rst_clk_pkg::OFF_SER_CTRL: rd = {24'h0, s.ser_ctrl};
      rst_clk_pkg::OFF_SER_RX: rd = {24'h0, s.ser_rx};
      rst_clk_pkg::OFF_SER_IRQ: rd = {24'h0, s.ser_irq};
      rst_clk_pkg::OFF_CMP_SEL: rd = {24'h0, s.cmp_sel};
      rst_clk_pkg::OFF_SUPERVISOR: rd = {28'h0, s.cm_armed, s.wd_armed, s.wd_win};
      rst_clk_pkg::OFF_STATE: rd = {24'h0, s.osc, s.wd_err, s.cm_err, s.core_reset, 2'h0,
        s.ram_undef};
      default: rd = 32'h0;
    endcase
    if (ar_hs)
    begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = rd;
      next_s.rsp.rresp = mapped(bus_req.araddr[7:0]) ? rst_clk_pkg::RESP_OKAY :
        rst_clk_pkg::RESP_SLVERR;
      if (bus_req.araddr[7:0] == rst_clk_pkg::OFF_STATUS)
        st_clr = 4'hf;
    end

    // Supervisor and clock monitor, only outside reset
    wd_on = !s.cfg[rst_clk_pkg::CFG_WD_DIS_BIT];
    if (s.seq == rst_clk_pkg::SEQ_RUN)
    begin
      if (wd_on && s.cm_armed)
      begin
        if (!clk_ok_s)
        begin
          next_s.cm_err = 1'b1;
          next_s.cm_cnt = 6'h00;
        end
        else if (s.cm_err)
        begin
          next_s.cm_cnt = s.cm_cnt + 6'h01;
          if (s.cm_cnt == rst_clk_pkg::CM_RECOVER_CYC - 6'h01)
            next_s.cm_err = 1'b0;
        end
      end
      if (wd_on && s.wd_armed)
      begin
        next_s.wd_cnt = s.wd_cnt + 1'b1;
        if (service)
        begin
          next_s.wd_cnt = '0;
          next_s.wd_err = 1'b0;
        end
        else if (s.wd_cnt >= win - 1'b1)
        begin
          next_s.wd_cnt = '0;
          next_s.wd_err = 1'b1;
        end
      end
    end

    // Power-on and external reset have the same effect on every register except the RAM-undefined mark, idle timer preset, halt exit and status bit each sets
    if (in_reset)
    begin
      next_s.data_seg = 8'h00;
      next_s.ser_presc = 8'h00;
      next_s.ser_ctrl = rst_clk_pkg::SER_CTRL_RESET;
      next_s.ser_rx = 8'h00;
      next_s.ser_irq = 8'h00;
      next_s.cmp_sel = 8'h00;
      next_s.wd_win = rst_clk_pkg::WD_WIN_RESET;
      next_s.wd_armed = wd_on;
      next_s.cm_armed = wd_on;
      next_s.wd_cnt = '0;
      next_s.wd_err = 1'b0;
      next_s.cm_err = 1'b0;
      next_s.cm_cnt = 6'h00;
    end
    // RAM content is only lost on power-on
    if (por_evt)
      next_s.ram_undef = 1'b1;

    ev[rst_clk_pkg::ST_POR] = por_evt;
    ev[rst_clk_pkg::ST_EXT] = ext_evt;
    ev[rst_clk_pkg::ST_CM] = next_s.cm_err && !s.cm_err;
    ev[rst_clk_pkg::ST_WD] = next_s.wd_err && !s.wd_err;
    // A new event outranks a clear in the same cycle
    next_s.status = (s.status & ~st_clr) | ev;

    next_s.rsp.awready = !next_s.aw_full;
    next_s.rsp.wready = !next_s.w_full;
    next_s.rsp.arready = !next_s.rsp.rvalid;
    next_s.core_reset = in_reset;
    next_s.halt_exit = ext_evt;
    next_s.irq = |(next_s.status & next_s.mask);
    next_s.err_oe = !next_s.cfg[rst_clk_pkg::CFG_WD_DIS_BIT];
    next_s.err_out = !(next_s.err_oe && (next_s.cm_err || next_s.wd_err));
    next_s.osc = rst_clk_pkg::osc_mode_t'({next_s.cfg[rst_clk_pkg::CFG_OSC_HI_BIT],
      next_s.cfg[rst_clk_pkg::CFG_OSC_LO_BIT]});
    next_s.drv_en = next_s.cfg[rst_clk_pkg::CFG_OSC_HI_BIT];
    next_s.gp_en = !next_s.cfg[rst_clk_pkg::CFG_OSC_HI_BIT];
    next_s.bias_en = next_s.osc == rst_clk_pkg::OSC_XTAL_BIAS;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.seq <= rst_clk_pkg::SEQ_EXT;
      s.cfg <= rst_clk_pkg::CFG_RESET;
      s.ser_ctrl <= rst_clk_pkg::SER_CTRL_RESET;
      s.wd_win <= rst_clk_pkg::WD_WIN_RESET;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
      s.core_reset <= 1'b1;
      s.err_out <= 1'b1;
      s.err_oe <= 1'b1;
      s.gp_en <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign bus_rsp = s.rsp;
  assign core_reset = s.core_reset;
  assign halt_exit = s.halt_exit;
  assign irq = s.irq;
  assign supervisor_error_pin_out = s.err_out;
  assign supervisor_error_pin_oe = s.err_oe;
  assign osc_mode = s.osc;
  assign osc_out_drive_en = s.drv_en;
  assign osc_out_gp_input_en = s.gp_en;
  assign osc_bias_res_en = s.bias_en;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_seg_cleared: assert property (s.core_reset |-> s.data_seg == 8'h00)
    else $error("data segment not cleared in reset");
  chk_serial_reset: assert property (s.core_reset |->
    s.ser_ctrl[rst_clk_pkg::TX_EMPTY_BIT] && s.ser_presc == 8'h00 && s.cmp_sel == 8'h00)
    else $error("serial or comparator registers wrong in reset");
  chk_window_max: assert property (s.core_reset |-> s.wd_win == rst_clk_pkg::WD_WIN_RESET)
    else $error("service window not at maximum in reset");
  chk_no_err_reset: assert property (s.core_reset |-> s.err_out && !s.cm_err && !s.wd_err)
    else $error("error flagged during reset");
  chk_cm_after_reset: assert property ($fell(s.core_reset) && s.cm_armed && s.err_oe
    && !clk_ok_s |=> s.cm_err ##0 !s.err_out)
    else $error("slow clock at reset end not flagged");
  chk_cm_recovery: assert property ($fell(s.cm_err) && !s.core_reset |->
    $past(clk_ok_s, 1) && $past(clk_ok_s, 16))
    else $error("monitor error ended too early");
  chk_halt_exit: assert property ($fell(rstn_s) |=> s.halt_exit)
    else $error("halt exit missing after reset pin low");
  chk_por_preset: assert property ($rose(vcc_s) && s.cfg[rst_clk_pkg::CFG_POR_EN_BIT] |=>
    s.idle_cnt == rst_clk_pkg::IDLE_PRESET && s.core_reset)
    else $error("power-on did not preset idle timer");
  chk_por_hold: assert property (s.seq == rst_clk_pkg::SEQ_POR && s.idle_cnt != 12'h000
    |=> s.core_reset)
    else $error("power-on reset released before underflow");
  chk_no_repeat_por: assert property (s.seq == rst_clk_pkg::SEQ_RUN && vcc_s
    && $past(vcc_s) |=> s.seq != rst_clk_pkg::SEQ_POR)
    else $error("power-on reset while supply steady");
  chk_osc_decode: assert property (s.osc == {s.cfg[rst_clk_pkg::CFG_OSC_HI_BIT],
    s.cfg[rst_clk_pkg::CFG_OSC_LO_BIT]} && s.drv_en == s.cfg[rst_clk_pkg::CFG_OSC_HI_BIT]
    && s.bias_en == (s.cfg[rst_clk_pkg::CFG_OSC_HI_BIT] && s.cfg[rst_clk_pkg::CFG_OSC_LO_BIT])
    && s.drv_en != s.gp_en)
    else $error("oscillator option decode wrong");
  chk_por_disabled: assert property (!s.cfg[rst_clk_pkg::CFG_POR_EN_BIT]
    && s.seq == rst_clk_pkg::SEQ_RUN |=> s.seq != rst_clk_pkg::SEQ_POR)
    else $error("power-on reset while disabled");
  chk_pin_disabled: assert property (s.cfg[rst_clk_pkg::CFG_WD_DIS_BIT] |-> !s.err_oe)
    else $error("error pin driven while supervisor disabled");
  chk_idle_count: assert property (!($rose(vcc_s) && s.cfg[rst_clk_pkg::CFG_POR_EN_BIT])
    |=> s.idle_cnt == $past(s.idle_cnt) - 12'h001)
    else $error("idle timer did not count down");
  chk_ext_release: assert property (s.seq == rst_clk_pkg::SEQ_EXT && rstn_s
    && !$rose(vcc_s) |=> !s.core_reset)
    else $error("external reset not released on edge");

  cov_por_done: cover property (s.seq == rst_clk_pkg::SEQ_POR ##1 s.seq == rst_clk_pkg::SEQ_RUN);
  cov_ext_reset: cover property (s.halt_exit ##[1:20] $fell(s.core_reset));
  cov_cm_error: cover property ($rose(s.cm_err) ##[1:40] $fell(s.cm_err));
  cov_irq: cover property ($rose(s.irq));
endmodule // reset_and_clock_option_ctrl

// ==== test/reset_source_model.sv ====
// Behavioural model of the external reset network, supply detector and clock source
`timescale 1ns/1ns
module reset_source_model (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic pulse_go,
  input wire logic [3:0] pulse_len,
  input wire logic supply_on,
  input wire logic osc_settled,
  // Pins seen by the block
  output logic reset_pin_n,
  output logic vcc_above_por,
  output logic clock_freq_ok
);
  logic [3:0] low_left = 4'h0;
  logic vcc_q = 1'b0;
  logic freq_ok_q = 1'b1;

  // A zero length still gives one full cycle low, the shortest valid reset
  always @(posedge clock)
  begin
    if (pulse_go)
      low_left <= (pulse_len == 4'h0) ? 4'h1 : pulse_len;
    else if (low_left != 4'h0)
      low_left <= low_left - 4'h1;
    vcc_q <= supply_on;
    freq_ok_q <= osc_settled;
  end

  assign reset_pin_n = (low_left == 4'h0);
  assign vcc_above_por = vcc_q;
  assign clock_freq_ok = freq_ok_q;
endmodule // reset_source_model

// ==== test/reset_and_clock_option_ctrl_tb.sv ====
// Self-checking bench for the reset sequencer and clock-option block
`timescale 1ns/1ns
module reset_and_clock_option_ctrl_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  rst_clk_pkg::axil_req_t bus_req = '0;
  rst_clk_pkg::axil_rsp_t bus_rsp;
  rst_clk_pkg::osc_mode_t osc_mode;
  logic pulse_go = 1'b0;
  logic [3:0] pulse_len = 4'h1;
  logic supply_on = 1'b0;
  logic osc_settled = 1'b1;
  logic reset_pin_n, vcc_above_por, clock_freq_ok;
  logic core_reset, halt_exit, irq, sup_out, sup_oe, drive_en, gp_en, bias_en;
  logic [31:0] rd;
  logic [1:0] resp;
  int error_cnt = 0;
  int num_checks = 0;
  int n;

  always #10 clock = ~clock;

  reset_and_clock_option_ctrl dut (
    .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .reset_pin_n(reset_pin_n), .vcc_above_por(vcc_above_por), .clock_freq_ok(clock_freq_ok),
    .core_reset(core_reset), .halt_exit(halt_exit), .irq(irq),
    .supervisor_error_pin_out(sup_out), .supervisor_error_pin_oe(sup_oe),
    .osc_mode(osc_mode), .osc_out_drive_en(drive_en), .osc_out_gp_input_en(gp_en),
    .osc_bias_res_en(bias_en)
  );

  reset_source_model partner (
    .clock(clock), .pulse_go(pulse_go), .pulse_len(pulse_len), .supply_on(supply_on),
    .osc_settled(osc_settled), .reset_pin_n(reset_pin_n), .vcc_above_por(vcc_above_por),
    .clock_freq_ok(clock_freq_ok)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
  begin
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  task automatic wait_for(ref logic sig, input logic val, input int lim, output int cnt);
  begin
    cnt = 0;
    while (sig !== val && cnt < lim)
    begin
      @(posedge clock);
      cnt++;
    end
    if (sig !== val)
    begin
      error_cnt++;
      $display("unexpected at %0t: wait timed out", $time);
    end
  end
  endtask

  // Address and data are offered together; each is dropped once its ready is seen
  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
    int t;
  begin
    t = 0;
    @(posedge clock);
    bus_req.awvalid <= 1'b1;
    bus_req.awaddr <= {24'h0, addr};
    bus_req.wvalid <= 1'b1;
    bus_req.wdata <= data;
    bus_req.wstrb <= 4'hf;
    bus_req.bready <= 1'b1;
    while (bus_rsp.bvalid !== 1'b1)
    begin
      @(posedge clock);
      t++;
      if (bus_rsp.awready === 1'b1)
        bus_req.awvalid <= 1'b0;
      if (bus_rsp.wready === 1'b1)
        bus_req.wvalid <= 1'b0;
    end
    check(t, 32'h3, "write answer latency");
    resp = bus_rsp.bresp;
    bus_req.bready <= 1'b0;
  end
  endtask

  task automatic axi_read(input logic [7:0] addr);
    int t;
  begin
    t = 0;
    @(posedge clock);
    bus_req.arvalid <= 1'b1;
    bus_req.araddr <= {24'h0, addr};
    bus_req.rready <= 1'b1;
    while (bus_rsp.rvalid !== 1'b1)
    begin
      @(posedge clock);
      t++;
      if (bus_rsp.arready === 1'b1)
        bus_req.arvalid <= 1'b0;
    end
    check(t, 32'h2, "read answer latency");
    rd = bus_rsp.rdata;
    resp = bus_rsp.rresp;
    bus_req.rready <= 1'b0;
  end
  endtask

  task automatic pin_pulse(input logic [3:0] len);
  begin
    @(posedge clock);
    pulse_go <= 1'b1;
    pulse_len <= len;
    @(posedge clock);
    pulse_go <= 1'b0;
  end
  endtask

  task automatic check_reset_values();
    logic [7:0] offs [4];
  begin
    offs = '{rst_clk_pkg::OFF_SER_PRESC, rst_clk_pkg::OFF_SER_RX, rst_clk_pkg::OFF_SER_IRQ,
      rst_clk_pkg::OFF_CMP_SEL};
    axi_read(rst_clk_pkg::OFF_DATA_SEG);
    check(rd, 32'h0, "data segment");
    axi_read(rst_clk_pkg::OFF_SER_CTRL);
    check(rd, {24'h0, rst_clk_pkg::SER_CTRL_RESET}, "serial control");
    foreach (offs[i])
    begin
      axi_read(offs[i]);
      check(rd, 32'h0, "serial or comparator");
    end
    axi_read(rst_clk_pkg::OFF_SUPERVISOR);
    check(rd, 32'h0000000f, "supervisor window and arm");
  end
  endtask

  task automatic test_por();
  begin
    supply_on <= 1'b1;
    wait_for(core_reset, 1'b1, 20, n);
    check({31'h0, core_reset}, 32'h1, "power-on reset start");
    wait_for(core_reset, 1'b0, 5000, n);
    check({31'h0, n >= 4096 && n <= 4106}, 32'h1, "power-on hold length");
    repeat (300) @(posedge clock);
    check({31'h0, core_reset}, 32'h0, "no second power-on reset");
    axi_read(rst_clk_pkg::OFF_STATUS);
    check({31'h0, rd[rst_clk_pkg::ST_POR]}, 32'h1, "power-on status");
    axi_read(rst_clk_pkg::OFF_STATE);
    check({31'h0, rd[0]}, 32'h1, "ram undefined mark");
    check_reset_values();
    $display("test power-on done");
  end
  endtask

  task automatic test_ext();
    int h;
    int r;
  begin
    h = 0;
    r = 0;
    axi_write(rst_clk_pkg::OFF_DATA_SEG, 32'h5a);
    axi_write(rst_clk_pkg::OFF_CMP_SEL, 32'h3);
    axi_read(rst_clk_pkg::OFF_DATA_SEG);
    check(rd, 32'h5a, "data segment written");
    pin_pulse(4'h1);
    repeat (8)
    begin
      @(posedge clock);
      h += (halt_exit === 1'b1);
      r += (core_reset === 1'b1);
    end
    check(h, 32'h1, "halt exit pulse");
    check({31'h0, r > 0}, 32'h1, "short pin pulse caught");
    wait_for(core_reset, 1'b0, 20, n);
    check({31'h0, n < 20}, 32'h1, "external reset release");
    check_reset_values();
    $display("test external reset done");
  end
  endtask

  task automatic test_osc();
  begin
    for (int m = 0; m < 4; m++)
    begin
      axi_write(rst_clk_pkg::OFF_CONFIG, 32'h40 | (m << 3));
      repeat (3) @(posedge clock);
      check(osc_mode, m, "oscillator mode");
      check({31'h0, drive_en}, m >> 1, "crystal drive");
      check({31'h0, gp_en}, (m >> 1) ^ 1, "general input");
      check({31'h0, bias_en}, m == 3, "bias resistor");
    end
    axi_write(rst_clk_pkg::OFF_CONFIG, 32'h40);
    $display("test oscillator done");
  end
  endtask

  task automatic test_monitor();
  begin
    pin_pulse(4'hc);
    wait_for(core_reset, 1'b1, 20, n);
    osc_settled <= 1'b0;
    repeat (4) @(posedge clock);
    check({31'h0, sup_out}, 32'h1, "no error inside reset");
    wait_for(core_reset, 1'b0, 30, n);
    repeat (2) @(posedge clock);
    check({31'h0, sup_out}, 32'h0, "monitor error after reset");
    axi_write(rst_clk_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0, "interrupt masked");
    axi_write(rst_clk_pkg::OFF_MASK, 32'h4);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h1, "interrupt raised");
    axi_read(rst_clk_pkg::OFF_STATUS);
    check({31'h0, rd[rst_clk_pkg::ST_CM]}, 32'h1, "monitor status");
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0, "interrupt cleared by read");
    osc_settled <= 1'b1;
    wait_for(sup_out, 1'b1, 60, n);
    check({31'h0, n >= 16 && n <= 35}, 32'h1, "monitor recovery time");
    $display("test clock monitor done");
  end
  endtask

  task automatic test_fuses();
  begin
    axi_write(rst_clk_pkg::OFF_CONFIG, 32'h44);
    axi_read(rst_clk_pkg::OFF_CONFIG);
    check(rd, 32'h44, "config readback");
    check({31'h0, sup_oe}, 32'h0, "supervisor pin released");
    axi_write(rst_clk_pkg::OFF_CONFIG, 32'h0);
    repeat (3) @(posedge clock);
    check({31'h0, sup_oe}, 32'h1, "supervisor pin driven");
    supply_on <= 1'b0;
    repeat (10) @(posedge clock);
    supply_on <= 1'b1;
    repeat (20) @(posedge clock);
    check({31'h0, core_reset}, 32'h0, "power-on path disabled");
    axi_read(8'h3c);
    check({30'h0, resp}, {30'h0, rst_clk_pkg::RESP_SLVERR}, "unmapped response");
    check(rd, 32'h0, "unmapped data");
    $display("test fuses done");
  end
  endtask

  // Shortest window code so that a missed service shows up in a few thousand cycles
  task automatic test_supervisor();
  begin
    axi_write(rst_clk_pkg::OFF_SUPERVISOR, 32'h0);
    wait_for(sup_out, 1'b0, 9000, n);
    check({31'h0, sup_out}, 32'h0, "supervisor timeout");
    axi_read(rst_clk_pkg::OFF_STATUS);
    check({31'h0, rd[rst_clk_pkg::ST_WD]}, 32'h1, "supervisor status");
    axi_write(rst_clk_pkg::OFF_SUPERVISOR, 32'h103);
    repeat (2) @(posedge clock);
    check({31'h0, sup_out}, 32'h1, "supervisor serviced");
    $display("test supervisor done");
  end
  endtask

  task automatic report_and_stop();
  begin
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    wait_for(core_reset, 1'b0, 20, n);
    test_por();
    test_ext();
    test_osc();
    test_monitor();
    test_fuses();
    test_supervisor();
    report_and_stop();
  end

  // The whole run needs about 13000 cycles
  initial
  begin
    #(20 * 40000);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    report_and_stop();
  end
endmodule // reset_and_clock_option_ctrl_tb
